// ---- core/adc_seq_params.svh ----
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// register byte offsets
`define CTRL_OFS       8'h00
`define STATUS_OFS     8'h04
`define RESULT_OFS     8'h08
`define IRQ_STAT_OFS   8'h0c
`define IRQ_MASK_OFS   8'h10

// control register fields
`define CTRL_CONT_BIT  0
`define CTRL_START_BIT 1
`define CTRL_EN_BIT    2
`define CTRL_FS_LSB    4
`define CTRL_OSR_LSB   8
`define CTRL_NEL_LSB   12
`define CTRL_CBIAS_LSB 16
`define CTRL_ABIAS_LSB 18
`define CTRL_STAGE_LSB 20
`define CTRL_WMASK     32'h00ff_3737
`define CTRL_RST       32'h0000_0000

// status and interrupt bits
`define STAT_BUSY_BIT  0
`define STAT_PEND_BIT  1
`define IRQ_DONE_BIT   0
`define IRQ_OVR_BIT    1

// timing: system clock and slowest sampling rate
`define CLK_HZ         200000000
`define FS_BASE_HZ     62500
`define FS_DIV_BASE    (`CLK_HZ / `FS_BASE_HZ)
`define OSR_BASE       14'd8

// full-scale result codes and bus answers
`define RES_MAX        16'h7fff
`define RES_MIN        16'h8000
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ---- core/adc_seq_pkg.sv ----
package adc_seq_pkg;

  // sequencer states, one-hot
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_RUN  = 2'b10
  } seq_state_t;

  // settings driven to the analog chain
  typedef struct packed {
    logic [3:0] stage_en;
    logic       converter_en;
    logic [1:0] converter_bias_sel;
    logic [1:0] amplifier_bias_sel;
  } analog_ctrl_t;

  // whole state of the sequencer and its bus slave
  typedef struct packed {
    seq_state_t  st;
    logic [31:0] ctrl;
    logic [15:0] result;
    logic [1:0]  stat;
    logic [1:0]  mask;
    logic        irq;
    logic [11:0] div_cnt;
    logic [11:0] div_len;
    logic [13:0] smp_cnt;
    logic [13:0] smp_total;
    logic [3:0]  force_len;
    logic        tick;
    logic        done;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } core_state_t;

endpackage

// ---- core/adc_conversion_sequencer.sv ----
// Function
// - two modes only, repeated or on request, chosen by the continuous bit.
// - repeated mode restarts a conversion right after the previous completes.
// - each completion loads the result register and pulses conversion done.
// - request mode starts only on the start bit; same internal sequence.
// - every conversion lasts the same time set by ratio, count and rate.
// - result is 16-bit two's complement.
// - overrange clamps to 0x7fff or 0x8000.
// - below 16-bit resolution low bits forced to one followed by zeros.
// - converter bias field selects quarter, half or full bias.
// - amplifier bias field selects quarter, half or full bias.
// - amplifier stages and converter can be switched off while idle.
// - rate field gives 62.5, 125, 250 or 500 kHz from the oscillator.
// - ratio is two to the power of code plus three, 8 to 1024.
// - elementary count is two to the power of code, 1 to 8.
// - duration is count times ratio plus one, plus one sample period.
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_params.svh"

module adc_conversion_sequencer
  import adc_seq_pkg::*;
#(
  parameter int RAW_W = 20
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [7:0]              awaddr,
  input  wire logic                    wvalid,
  output logic                         wready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  output logic                         bvalid,
  input  wire logic                    bready,
  output logic [1:0]                   bresp,
  input  wire logic                    arvalid,
  output logic                         arready,
  input  wire logic [7:0]              araddr,
  output logic                         rvalid,
  input  wire logic                    rready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  input  wire logic signed [RAW_W-1:0] raw_value,
  output analog_ctrl_t                 analog_ctrl,
  output logic                         sample_tick,
  output logic                         conv_run,
  output logic                         conv_done,
  output logic                         irq
);

  localparam logic [RAW_W-1:0] RAW_MAX = {{(RAW_W-16){1'b0}}, `RES_MAX};
  localparam logic [RAW_W-1:0] RAW_MIN = {{(RAW_W-16){1'b1}}, `RES_MIN};

  core_state_t s;
  core_state_t n;

  // count of low bits forced for each ratio and count setting
  function automatic logic [3:0] force_bits(input logic [2:0] oversampling_ratio,
                                            input logic [1:0] nel);
    logic [3:0] len;
    len = 4'd0;
    unique case ({oversampling_ratio, nel})
      5'b000_00: len = 4'd9;
      5'b000_01: len = 4'd8;
      5'b000_10: len = 4'd7;
      5'b000_11: len = 4'd7;
      5'b001_00: len = 4'd7;
      5'b001_01: len = 4'd7;
      5'b001_10: len = 4'd6;
      5'b001_11: len = 4'd5;
      5'b010_00: len = 4'd6;
      5'b010_01: len = 4'd5;
      5'b010_10: len = 4'd4;
      5'b010_11: len = 4'd3;
      5'b011_00: len = 4'd4;
      5'b011_01: len = 4'd3;
      5'b011_10: len = 4'd2;
      5'b011_11: len = 4'd1;
      5'b100_00: len = 4'd2;
      5'b100_01: len = 4'd1;
      default:   len = 4'd0;
    endcase
    return len;
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        v[8*i +: 8] = data[8*i +: 8];
      end
    end
    return v;
  endfunction

  logic [2:0]        osr_sel;
  logic [1:0]        nel_sel;
  logic [1:0]        fs_sel;
  logic              cont;
  logic              en;
  logic              start_ok;
  logic              do_wr;
  logic [31:0]       wval;
  logic [1:0]        clr;
  logic [1:0]        set;
  logic [15:0]       clamped;
  logic [15:0]       fmsk;
  logic signed [RAW_W-1:0] rmax;
  logic signed [RAW_W-1:0] rmin;

  // configuration fields in use
  assign osr_sel = s.ctrl[`CTRL_OSR_LSB +: 3];
  assign nel_sel = s.ctrl[`CTRL_NEL_LSB +: 2];
  assign fs_sel  = s.ctrl[`CTRL_FS_LSB +: 2];
  assign cont    = s.ctrl[`CTRL_CONT_BIT];
  assign en      = s.ctrl[`CTRL_EN_BIT];
  assign rmax    = RAW_MAX;
  assign rmin    = RAW_MIN;

  // next state
  always_comb begin
    n      = s;
    n.tick = 1'b0;
    n.done = 1'b0;
    clr    = 2'b00;
    set    = 2'b00;
    wval   = merge(s.wdata & 32'h0, s.wdata, s.wstrb);
    do_wr  = s.aw_held && s.w_held && !s.bvalid;
    start_ok = 1'b0;
    clamped  = 16'h0;
    fmsk     = 16'h0;

    // write channels
    if (awvalid && s.awready) begin
      n.aw_held = 1'b1;
      n.awaddr  = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_held = 1'b1;
      n.wdata  = wdata;
      n.wstrb  = wstrb;
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (do_wr) begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = `RESP_OKAY;
      unique case (s.awaddr)
        `CTRL_OFS: begin
          n.ctrl = merge(s.ctrl, s.wdata, s.wstrb) & `CTRL_WMASK;
          if (s.st == SEQ_RUN) begin
            n.ctrl[`CTRL_START_BIT] = s.ctrl[`CTRL_START_BIT];
          end
        end
        `IRQ_STAT_OFS: clr = wval[1:0];
        `IRQ_MASK_OFS: n.mask = s.wstrb[0] ? s.wdata[1:0] : s.mask;
        `STATUS_OFS, `RESULT_OFS: ;
        default: n.bresp = `RESP_SLVERR;
      endcase
    end

    // read channel
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = `RESP_OKAY;
      unique case (araddr)
        `CTRL_OFS:     n.rdata = s.ctrl;
        `STATUS_OFS:   n.rdata = {30'h0, s.ctrl[`CTRL_START_BIT], s.st[1]};
        `RESULT_OFS:   n.rdata = {16'h0, s.result};
        `IRQ_STAT_OFS: n.rdata = {30'h0, s.stat};
        `IRQ_MASK_OFS: n.rdata = {30'h0, s.mask};
        default: begin
          n.rdata = 32'h0;
          n.rresp = `RESP_SLVERR;
        end
      endcase
    end

    // sequencer
    start_ok = en && (cont || s.ctrl[`CTRL_START_BIT]);
    unique case (s.st)
      SEQ_IDLE: begin
        if (start_ok) begin
          n.st        = SEQ_RUN;
          n.div_cnt   = 12'h0;
          n.smp_cnt   = 14'h0;
          n.div_len   = 12'(`FS_DIV_BASE >> fs_sel);
          n.smp_total = (((`OSR_BASE << osr_sel) + 14'h1) << nel_sel)
                        + 14'h1;
          n.force_len = force_bits(osr_sel, nel_sel);
        end
      end
      SEQ_RUN: begin
        if (!en) begin
          n.st = SEQ_IDLE;
          n.ctrl[`CTRL_START_BIT] = 1'b0;
        end else if (s.div_cnt == s.div_len - 12'h1) begin
          n.div_cnt = 12'h0;
          n.tick    = 1'b1;
          n.smp_cnt = s.smp_cnt + 14'h1;
          if (s.smp_cnt == s.smp_total - 14'h1) begin
            // saturate on overrange, otherwise force non-significant bits
            if ($signed(raw_value) > rmax) begin
              clamped = `RES_MAX;
              set[`IRQ_OVR_BIT] = 1'b1;
            end else if ($signed(raw_value) < rmin) begin
              clamped = `RES_MIN;
              set[`IRQ_OVR_BIT] = 1'b1;
            end else begin
              fmsk    = (16'h1 << s.force_len) - 16'h1;
              clamped = (raw_value[15:0] & ~fmsk)
                        | (fmsk ^ (fmsk >> 1));
            end
            n.result = clamped;
            n.done   = 1'b1;
            set[`IRQ_DONE_BIT] = 1'b1;
            n.ctrl[`CTRL_START_BIT] = 1'b0;
            n.smp_cnt = 14'h0;
            if (cont) begin
              n.div_len   = 12'(`FS_DIV_BASE >> fs_sel);
              n.smp_total = (((`OSR_BASE << osr_sel) + 14'h1) << nel_sel)
                            + 14'h1;
              n.force_len = force_bits(osr_sel, nel_sel);
            end else begin
              n.st = SEQ_IDLE;
            end
          end
        end else begin
          n.div_cnt = s.div_cnt + 12'h1;
        end
      end
      default: n.st = SEQ_IDLE;
    endcase

    // sticky flags, set beats clear
    n.stat    = (s.stat & ~clr) | set;
    n.irq     = |(n.stat & n.mask);
    n.awready = !n.aw_held && !n.bvalid;
    n.wready  = !n.w_held && !n.bvalid;
    n.arready = !n.rvalid;
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s      <= '0;
      s.st   <= SEQ_IDLE;
      s.ctrl <= `CTRL_RST;
    end else begin
      s <= n;
    end
  end

  // outputs straight from state
  assign awready = s.awready;
  assign wready  = s.wready;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = s.arready;
  assign rvalid  = s.rvalid;
  assign rdata   = s.rdata;
  assign rresp   = s.rresp;
  assign sample_tick = s.tick;
  assign conv_run    = s.st[1];
  assign conv_done   = s.done;
  assign irq         = s.irq;
  assign analog_ctrl = {s.ctrl[`CTRL_STAGE_LSB +: 4],
                        s.ctrl[`CTRL_EN_BIT],
                        s.ctrl[`CTRL_CBIAS_LSB +: 2],
                        s.ctrl[`CTRL_ABIAS_LSB +: 2]};

  // helper counters for timing checks
  logic [25:0] h_cyc;
  logic [11:0] h_gap;
  always_ff @(posedge aclk) begin
    if (!aresetn || !s.st[1]) begin
      h_cyc <= 26'h0;
      h_gap <= 12'h0;
    end else begin
      h_cyc <= s.done ? 26'h1 : h_cyc + 26'h1;
      h_gap <= s.tick ? 12'h1 : h_gap + 12'h1;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence idle_to_run;
    !s.st[1] ##1 s.st[1];
  endsequence

  sequence run_done;
    s.st[1] ##1 s.done;
  endsequence

  a_repeat_restart: assert property (
    run_done |-> ($past(cont) && $past(en)) == s.st[1])
    else $error("repeated mode did not restart");

  a_done_flags: assert property (
    s.done |-> s.stat[`IRQ_DONE_BIT] && !$past(s.done))
    else $error("done without sticky flag");

  a_request_start: assert property (
    idle_to_run |-> $past(en) && ($past(cont) || $past(s.ctrl[`CTRL_START_BIT])))
    else $error("conversion began without request");

  a_conv_length: assert property (
    s.done |-> h_cyc == 26'($past(s.smp_total)) * 26'($past(s.div_len)))
    else $error("conversion time wrong");

  a_twos_compl: assert property (
    s.done && $past(s.force_len) == 4'h0 && $signed($past(raw_value)) <= rmax
    && $signed($past(raw_value)) >= rmin |-> s.result == $past(raw_value[15:0]))
    else $error("result not the raw two's complement value");

  a_sat_clamp: assert property (
    s.done && $signed($past(raw_value)) > rmax |-> s.result == `RES_MAX
    && s.stat[`IRQ_OVR_BIT])
    else $error("positive overrange not clamped");

  a_forced_bits: assert property (
    s.done && $signed($past(raw_value)) <= rmax && $signed($past(raw_value)) >= rmin
    |-> ((s.result ^ ((16'h1 << $past(s.force_len)) >> 1))
        & ((16'h1 << $past(s.force_len)) - 16'h1)) == 16'h0)
    else $error("low bits not forced");

  a_tick_period: assert property (
    s.tick && !s.done |-> h_gap == s.div_len)
    else $error("sample period wrong");

  a_busy_ignore: assert property (
    s.st[1] && !s.ctrl[`CTRL_START_BIT] |=> !s.ctrl[`CTRL_START_BIT])
    else $error("request taken while busy");

  a_disable_stop: assert property (
    !en |=> !s.st[1])
    else $error("conversion kept running while disabled");

endmodule

`default_nettype wire

// ---- bench/adc_front_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module adc_front_model
  import adc_seq_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               conv_run,
  input  wire analog_ctrl_t       analog_ctrl,
  input  wire logic signed [19:0] level,
  output var logic signed [19:0]  raw_value
);
  // accumulator tracks the input only while powered and converting
  always @(posedge aclk) begin
    if (conv_run && analog_ctrl.converter_en) begin
      raw_value <= level;
    end else begin
      raw_value <= ~level; // idle output shows the inverse of the input
    end
  end
endmodule

`default_nettype wire

// ---- bench/adc_conversion_sequencer_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_params.svh"

`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, a); end end

module adc_conversion_sequencer_tb
  import adc_seq_pkg::*;
;
  logic               aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready, sample_tick, conv_run, conv_done, irq;
  logic [7:0]         awaddr, araddr;
  logic [31:0]        wdata, rdata, v;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp, r, wresp;
  logic signed [19:0] level, raw_value;
  analog_ctrl_t       analog_ctrl;
  logic               prev_run = 0;
  int                 bad_count = 0, compares = 0, cyc = 0, t_run = 0, t_done = 0;
  int                 t_prev = 0, ndone = 0, ntick = 0;
  logic [1:0]         bc [4] = '{2'h0, 2'h1, 2'h3, 2'h3};
  logic signed [19:0] lv [3] = '{-20'sd1, 20'sd40000, -20'sd40000};
  logic [31:0]        ex [3] = '{32'hff80, 32'h7fff, 32'h8000};

  adc_conversion_sequencer i_adc_conversion_sequencer (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .raw_value, .analog_ctrl, .sample_tick,
    .conv_run, .conv_done, .irq);

  adc_front_model i_adc_front_model (.aclk, .conv_run, .analog_ctrl, .level, .raw_value);

  always #2.5 aclk = ~aclk;

  // edge stamps of conversion start and completion
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    prev_run <= conv_run;
    if (conv_run && !prev_run) begin
      t_run <= cyc;
      ntick <= 0;
    end else if (sample_tick) ntick <= ntick + 1;
    if (conv_done) begin
      t_prev <= t_done;
      t_done <= cyc;
      ndone <= ndone + 1;
    end
  end

  task automatic wrap_up;
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1;
    repeat (1000) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid && bready) begin
        wresp = bresp;
        bready <= 0;
        return;
      end
    end
    bad_count++;
    wrap_up();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    repeat (1000) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid && rready) begin
        d = rdata;
        rs = rresp;
        rready <= 0;
        return;
      end
    end
    bad_count++;
    wrap_up();
  endtask

  // bounded wait for the next completion pulse
  task automatic wait_done;
    int k0;
    k0 = ndone;
    repeat (40000) begin
      @(posedge aclk);
      #1;
      if (ndone != k0) return;
    end
    bad_count++;
    wrap_up();
  endtask

  initial begin
    aclk = 0;
    aresetn = 0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    level = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(`CTRL_OFS, v, r);
    `CHK("ctrl reset", 32'h0, v)
    `CHK("analog reset", 9'h0, analog_ctrl)
    rd(8'h14, v, r);
    `CHK("unmapped resp", `RESP_SLVERR, r)
    wr(8'h14, 32'h0);
    `CHK("unmapped wresp", `RESP_SLVERR, wresp)
    wr(`RESULT_OFS, 32'hffff);
    `CHK("ro wresp", `RESP_OKAY, wresp)
    rd(`RESULT_OFS, v, r);
    `CHK("ro result", 32'h0, v)
    // request mode over every rate, one stage at a time and bias codes 0, 1 and 3
    for (int i = 0; i < 4; i++) begin
      level <= 20'sd1234 + 20'(i);
      wr(`CTRL_OFS, {8'h0, 4'(1 << i), bc[3-i], bc[i], 10'h0, 2'(i), 4'b0110});
      `CHK("bias out", {4'(1 << i), 1'b1, bc[i], bc[3-i]}, analog_ctrl)
      rd(`STATUS_OFS, v, r);
      `CHK("busy", 1'b1, v[0])
      wr(`CTRL_OFS, {8'h0, 4'(1 << i), bc[3-i], bc[i], 10'h0, 2'(i), 4'b0110});
      wait_done();
      `CHK("conv time", 10 * (3200 >> i), t_done - t_run)
      `CHK("tick count", 10, ntick)
      rd(`RESULT_OFS, v, r);
      `CHK("result", 32'h500, v)
      rd(`CTRL_OFS, v, r);
      `CHK("start clear", 1'b0, v[1])
      repeat (50) @(posedge aclk);
      `CHK("no rerun", 1'b0, conv_run)
      `CHK("irq masked", 1'b0, irq)
      rd(`IRQ_STAT_OFS, v, r);
      `CHK("done flag", 1'b1, v[0])
      wr(`IRQ_MASK_OFS, 32'h3);
      repeat (2) @(posedge aclk);
      `CHK("irq set", 1'b1, irq)
      wr(`IRQ_STAT_OFS, 32'h1);
      repeat (2) @(posedge aclk);
      `CHK("irq clear", 1'b0, irq)
      wr(`IRQ_MASK_OFS, 32'h0);
    end
    // repeated mode: format, clamping and back-to-back timing
    for (int k = 0; k < 3; k++) begin
      level <= lv[k];
      if (k == 0) wr(`CTRL_OFS, 32'h00f0_1035);
      wait_done();
      if (k > 0) begin
        `CHK("period", 19 * 400, t_done - t_prev)
        `CHK("still run", 1'b1, conv_run)
      end
      rd(`RESULT_OFS, v, r);
      `CHK("cont result", ex[k], v)
      if (k == 1) begin
        wr(`CTRL_OFS, 32'h00f0_1037);
        rd(`STATUS_OFS, v, r);
        `CHK("start ignored", 2'b01, v[1:0])
      end
    end
    rd(`IRQ_STAT_OFS, v, r);
    `CHK("overrange flag", 1'b1, v[1])
    wr(`CTRL_OFS, 32'h0);
    repeat (2) @(posedge aclk);
    `CHK("stopped", 1'b0, conv_run)
    `CHK("powered down", 9'h0, analog_ctrl)
    wrap_up();
  end
endmodule

`default_nettype wire
